// [pcm_serial_port.sv]
`timescale 1ns/10ps
`default_nettype none

// Function
// - Master clock stopped forces power-down and releases transmit output.
// - Power-down request waits until the current transmit word is sent.
// - Law select low picks 13-bit linear, high picks 8-bit A-law.
// - Linear samples are 13-bit two's-complement values.
// - Companded samples use A-law encoding and decoding.
// - Transmit mute high silences the transmit sample.
// - Receive mute high silences the received sample.
// - Companded receive frame carries 8 code bits, MSB first.
// - Linear receive frame carries 13 sample bits, MSB first.
// - Linear receive bits 14 to 16 carry the 3-bit volume field.
// - Volume code 000 is +3 dB, each step lowers 3 dB to -18.
// - Companded mode uses fixed 0 dB gain, no volume bits taken.
// - Serial bit timing derives from master clock edges; the clock loss timeout counts aclk cycles.
// - Transmit bits driven on rising edges, then output released.
// - Frame sync and receive data sampled on falling edges.
module pcm_serial_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire pcm_port_pkg::pin_in_s pins,
  output logic serial_tx_data_out,
  output logic serial_tx_data_oe,
  output logic power_down,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import pcm_port_pkg::*;

  // ****************************************
  // A-law helpers
  // ****************************************
  function automatic logic [7:0] alaw_encode(input logic [12:0] s);
    logic [11:0] mag;
    logic [2:0] seg;
    logic [3:0] man;
    mag = s[12] ? ~s[11:0] : s[11:0];
    seg = 3'h0;
    man = mag[4:1];
    for (int i = 5; i <= 11; i++) begin
      if (mag[i]) begin
        seg = 3'(i - 4);
        man = 4'(mag >> (i - 4));
      end
    end
    return {~s[12], seg, man} ^ ALAW_XOR;
  endfunction : alaw_encode

  function automatic logic [12:0] alaw_decode(input logic [7:0] code);
    logic [7:0] c;
    logic [11:0] mag;
    c = code ^ ALAW_XOR;
    if (c[6:4] == 3'h0) begin
      mag = {7'h00, c[3:0], 1'b1};
    end else begin
      mag = 12'({1'b1, c[3:0], 1'b1}) << (c[6:4] - 3'h1);
    end
    return c[7] ? {1'b0, mag} : ~{1'b0, mag};
  endfunction : alaw_decode

  // ****************************************
  // Pin synchronisers and master clock edges
  // ****************************************
  pin_in_s sync1, sync2;
  logic mclk_prev;
  logic [8:0] loss_cnt;
  always_ff @(posedge aclk) begin
    sync1 <= pins;
    sync2 <= sync1;
    mclk_prev <= sync2.mclk;
  end

  wire rise_evt = sync2.mclk & ~mclk_prev;
  wire fall_evt = ~sync2.mclk & mclk_prev;
  wire mclk_lost = (loss_cnt == 9'(MCLK_LOSS_CYC));

  always_ff @(posedge aclk) begin
    if (!aresetn || rise_evt || fall_evt) begin
      loss_cnt <= 9'h000;
    end else if (!mclk_lost) begin
      loss_cnt <= loss_cnt + 9'h001;
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  logic [31:0] ctrl, tx_sample;
  logic [12:0] rx_sample;
  logic [15:0] rx_word;
  logic [2:0] rx_gain;
  logic [7:0] frame_cnt;

  // ****************************************
  // Frame control
  // ****************************************
  logic tx_active, tx_start_pend, law_frame;
  logic [4:0] tx_cnt, rx_cnt;
  logic [12:0] tx_shift;
  logic [15:0] rx_shift;
  logic rx_active;

  wire sw_pd = ctrl[CTRL_PD_BIT];
  wire pd_now = mclk_lost | (sw_pd & ~tx_active & ~tx_start_pend);
  wire frame_start = fall_evt & sync2.frame_sync & ~pd_now;
  wire [4:0] tx_len = law_frame ? CMP_BITS : LIN_TX_BITS;
  wire [4:0] rx_len = law_frame ? CMP_BITS : LIN_RX_BITS;
  wire [12:0] tx_lin = sync2.tx_mute ? 13'h0000 : tx_sample[12:0];
  wire [12:0] tx_load = sync2.law_select ?
    {alaw_encode(tx_lin), 5'h00} : tx_lin;
  wire [15:0] rx_next_shift = {rx_shift[14:0], sync2.rx_data};
  wire rx_done = fall_evt & rx_active & (rx_cnt == rx_len - 5'h01);
  wire [12:0] rx_lin = law_frame ?
    alaw_decode(rx_next_shift[7:0]) : rx_next_shift[15:3];
  wire [2:0] next_gain = law_frame ?
    GAIN_0DB_CODE : rx_next_shift[2:0];
  wire [7:0] gain_db = GAIN_TOP_DB - 8'({rx_gain, 1'b0}) - 8'(rx_gain);

  always_ff @(posedge aclk) begin
    if (!aresetn || mclk_lost) begin
      tx_active <= 1'b0;
      tx_start_pend <= 1'b0;
      tx_cnt <= 5'h00;
      serial_tx_data_oe <= 1'b0;
      serial_tx_data_out <= 1'b0;
      law_frame <= 1'b0;
    end else if (frame_start) begin
      tx_start_pend <= 1'b1;
      tx_shift <= tx_load;
      law_frame <= sync2.law_select;
    end else if (rise_evt && (tx_start_pend || tx_active) &&
                 tx_cnt != tx_len) begin
      serial_tx_data_oe <= 1'b1;
      serial_tx_data_out <= tx_shift[12];
      tx_shift <= {tx_shift[11:0], 1'b0};
      tx_cnt <= tx_cnt + 5'h01;
      tx_active <= 1'b1;
      tx_start_pend <= 1'b0;
    end else if (fall_evt && tx_active && tx_cnt == tx_len) begin
      serial_tx_data_oe <= 1'b0;
      tx_active <= 1'b0;
      tx_cnt <= 5'h00;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || mclk_lost) begin
      rx_active <= 1'b0;
      rx_cnt <= 5'h00;
      rx_shift <= 16'h0000;
    end else if (frame_start) begin
      rx_active <= 1'b1;
      rx_cnt <= 5'h00;
    end else if (fall_evt && rx_active) begin
      rx_shift <= rx_next_shift;
      rx_cnt <= rx_cnt + 5'h01;
      rx_active <= !rx_done;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_sample <= 13'h0000;
      rx_word <= 16'h0000;
      rx_gain <= GAIN_0DB_CODE;
      frame_cnt <= 8'h00;
      power_down <= 1'b1;
    end else begin
      power_down <= pd_now;
      if (rx_done) begin
        rx_sample <= sync2.rx_mute ? 13'h0000 : rx_lin;
        rx_word <= rx_next_shift;
        rx_gain <= next_gain;
        frame_cnt <= frame_cnt + 8'h01;
      end
    end
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic [7:0] aw_addr, ar_addr_q;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_held, w_held;

  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire wr_ctrl = do_write & (aw_addr == CTRL_OFS);
  wire wr_txs = do_write & (aw_addr == TX_SAMPLE_OFS);
  wire wr_ok = wr_ctrl | wr_txs;
  wire [31:0] mask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                      {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] status = {gain_db, frame_cnt, 5'h00, rx_gain,
                        2'h0, sync2.tx_mute, sync2.rx_mute,
                        tx_active, law_frame, mclk_lost, pd_now};
  wire rd_hit_ctrl = (ar_addr_q == CTRL_OFS);
  wire rd_hit_tx = (ar_addr_q == TX_SAMPLE_OFS);
  wire rd_hit_rx = (ar_addr_q == RX_SAMPLE_OFS);
  wire rd_hit_st = (ar_addr_q == STATUS_OFS);
  wire rd_hit_wd = (ar_addr_q == RX_WORD_OFS);
  wire rd_hit = rd_hit_ctrl | rd_hit_tx | rd_hit_rx | rd_hit_st | rd_hit_wd;
  wire [31:0] rd_mux =
    rd_hit_ctrl ? ctrl :
    rd_hit_tx ? tx_sample :
    rd_hit_rx ? {{19{rx_sample[12]}}, rx_sample} :
    rd_hit_st ? status :
    rd_hit_wd ? {16'h0000, rx_word} : 32'h0000_0000;
  logic rd_pend;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      ctrl <= CTRL_RESET;
      tx_sample <= TX_SAMPLE_RESET;
    end else begin
      if (aw_hs) begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (w_hs) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl <= (ctrl & ~mask) | (w_data & mask);
      end
      if (wr_txs) begin
        tx_sample <= (tx_sample & ~mask) | (w_data & mask);
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_DECERR;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
      rd_pend <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      ar_addr_q <= s_axi_araddr;
      s_axi_arready <= 1'b0;
      rd_pend <= 1'b1;
    end else if (rd_pend) begin
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_DECERR;
      s_axi_rvalid <= 1'b1;
      rd_pend <= 1'b0;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence seq_last_bit;
    fall_evt && tx_active && tx_cnt == tx_len && !mclk_lost;
  endsequence

  tx_hiz_lost_a: assert property (mclk_lost |=> !serial_tx_data_oe)
    else $error("transmit output driven after clock loss");
  pd_defer_a: assert property (
    tx_active && sw_pd && !mclk_lost && !fall_evt |=> tx_active && !pd_now)
    else $error("power-down cut a transmit word");
  law_width_a: assert property (
    $rose(tx_active) |-> tx_len == (law_frame ? 5'h08 : 5'h0d))
    else $error("transmit width does not follow law");
  alaw_mute_a: assert property (
    frame_start && sync2.tx_mute && sync2.law_select |=> tx_shift[12:5] == 8'hd5)
    else $error("muted A-law word is not the zero code");
  lin_mute_a: assert property (
    frame_start && sync2.tx_mute && !sync2.law_select |=> tx_shift == 13'h0000)
    else $error("muted linear word not zero");
  rx_mute_a: assert property (
    rx_done && sync2.rx_mute |=> rx_sample == 13'h0000)
    else $error("receive mute ignored");
  gain_fixed_a: assert property (
    rx_done && law_frame |=> rx_gain == 3'h1 && gain_db == 8'h00)
    else $error("companded gain not 0 dB");
  gain_field_a: assert property (
    rx_done && !law_frame |=> rx_gain == $past(rx_next_shift[2:0]))
    else $error("volume field decode wrong");
  first_bit_a: assert property (
    rise_evt && tx_start_pend && !mclk_lost |=>
    serial_tx_data_oe && serial_tx_data_out == $past(tx_shift[12]))
    else $error("bit 1 not driven after frame start");
  release_a: assert property (seq_last_bit |=> !serial_tx_data_oe)
    else $error("output not released after last bit");

endmodule : pcm_serial_port

`default_nettype wire

// [pcm_port_pkg.sv]
package pcm_port_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TX_SAMPLE_OFS = 8'h04;
  localparam logic [7:0] RX_SAMPLE_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] RX_WORD_OFS = 8'h10;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] TX_SAMPLE_RESET = 32'h0000_0000;
  localparam int CTRL_PD_BIT = 0;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam logic [4:0] LIN_TX_BITS = 5'h0d;
  localparam logic [4:0] LIN_RX_BITS = 5'h10;
  localparam logic [4:0] CMP_BITS = 5'h08;
  localparam logic [7:0] ALAW_XOR = 8'h55;
  localparam logic [2:0] GAIN_0DB_CODE = 3'h1;
  localparam logic [7:0] GAIN_TOP_DB = 8'h03;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 125;
  localparam int MCLK_LOSS_NS = 2000;
  localparam int MCLK_LOSS_CYC = MCLK_LOSS_NS * CLK_MHZ / 1000;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic mclk;
    logic frame_sync;
    logic rx_data;
    logic law_select;
    logic tx_mute;
    logic rx_mute;
  } pin_in_s;

  typedef enum logic [1:0] {
    RESP_OKAY = 2'b00,
    RESP_DECERR = 2'b11
  } axi_resp_e;

endpackage : pcm_port_pkg

// [pcm_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ********
// Host side of the serial link
// ********
module pcm_host_model (
  input wire logic run,
  input wire logic [15:0] rx_word,
  input wire logic tx_out,
  input wire logic tx_oe,
  output logic mclk,
  output logic frame_sync,
  output logic rx_data,
  output logic [7:0] phase,
  output logic [15:0] tx_word,
  output logic [4:0] tx_bits
);
  logic [7:0] nxt;
  assign nxt = phase + 8'h01;
  initial begin
    mclk = 1'b0;
    frame_sync = 1'b0;
    rx_data = 1'b0;
    phase = 8'h00;
    tx_word = 16'h0000;
    tx_bits = 5'h00;
    // Master clock runs from time zero, reset included
    forever #244.14 mclk = run ? ~mclk : mclk;
  end
  // One sync every 256 master clocks, data launched on rising edges
  always @(posedge mclk) begin
    phase <= nxt;
    frame_sync <= (phase == 8'hfe);
    if (nxt < 8'h10) begin
      rx_data <= rx_word[4'hf - nxt[3:0]];
    end else begin
      rx_data <= ~rx_data;
    end
  end
  // Capture what the device drives, one bit per falling edge
  always @(negedge mclk) begin
    if (frame_sync) begin
      tx_word <= 16'h0000;
      tx_bits <= 5'h00;
    end else if (tx_oe) begin
      tx_word <= {tx_word[14:0], tx_out};
      tx_bits <= tx_bits + 5'h01;
    end
  end
endmodule : pcm_host_model
`default_nettype wire

// [voice_pcm_serial_port_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module voice_pcm_serial_port_bench;
  import pcm_port_pkg::*;
  logic aclk, aresetn, run, law, txm, rxm, mclk, fsync, rxd;
  logic serial_tx_data_out, serial_tx_data_oe, power_down;
  logic [15:0] rx_word, tx_word;
  logic [4:0] tx_bits;
  logic [7:0] phase, s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [12:0] smp;
  pin_in_s pins;
  int n_errors, samples_checked, cycles;
  assign pins = {mclk, fsync, rxd, law, txm, rxm};
  pcm_serial_port dut_u (.*);
  pcm_host_model host_u (.run(run), .rx_word(rx_word),
    .tx_out(serial_tx_data_out), .tx_oe(serial_tx_data_oe), .mclk(mclk),
    .frame_sync(fsync), .rx_data(rxd), .phase(phase), .tx_word(tx_word),
    .tx_bits(tx_bits));
  // ********
  // Checking and bus tasks
  // ********
  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk
  function automatic logic [31:0] st_exp(input logic l, input logic [2:0] c);
    logic [7:0] db;
    db = GAIN_TOP_DB - 8'(c) * 8'h03;
    return {db, 13'h0, c, 5'h0, l, 2'h0};
  endfunction : st_exp
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw && w));
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  // Runs one frame with the given pins and checks transmit, and receive only when pd is low
  task automatic frame(input logic l, tm, rm, pd, input logic [2:0] vol);
    logic [12:0] tx;
    tx = 13'($urandom);
    smp = 13'($urandom);
    wr(TX_SAMPLE_OFS, {19'h0, tx});
    rd(TX_SAMPLE_OFS);
    chk("tx_sample", {19'h0, tx}, d);
    rx_word <= {smp, vol};
    law <= l;
    txm <= tm;
    rxm <= rm;
    @(posedge fsync);
    if (pd) begin
      wait (phase == 8'h04);
      @(posedge aclk);
      wr(CTRL_OFS, 32'h1);
      chk("power_down", 32'h0, 32'(power_down));
    end
    wait (phase == 8'h28);
    @(posedge aclk);
    chk("tx_bits", l ? 32'h8 : 32'hd, 32'(tx_bits));
    chk("tx_word", l ? 32'hd5 : (tm ? 32'h0 : 32'(tx)), 32'(tx_word));
    if (pd) begin
      chk("power_down", 32'h1, 32'(power_down));
    end else begin
      rd(RX_SAMPLE_OFS);
      chk("rx_sample", rm ? 32'h0 : 32'($signed(smp)), d);
      rd(STATUS_OFS);
      chk("status", st_exp(l, l ? GAIN_0DB_CODE : vol), d & 32'hff00_0704);
    end
  endtask : frame
  // ********
  // Clock, timeout and main sequence
  // ********
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 92000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    {aresetn, law, txm, rxm, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rx_word} = '0;
    s_axi_wstrb = 4'hf;
    run = 1'b1;
    n_errors = 0;
    samples_checked = 0;
    cycles = 0;
    void'($urandom(41818));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(CTRL_OFS);
    chk("ctrl", CTRL_RESET, d);
    rd(TX_SAMPLE_OFS);
    chk("tx_sample", TX_SAMPLE_RESET, d);
    rd(8'h20);
    chk("rresp", 32'(RESP_DECERR), 32'(r));
    wr(RX_SAMPLE_OFS, 32'h1);
    chk("bresp", 32'(RESP_DECERR), 32'(r));
    frame(1'b0, 1'b0, 1'b0, 1'b0, 3'h7);
    frame(1'b1, 1'b1, 1'b1, 1'b0, 3'h2);
    frame(1'b0, 1'b0, 1'b0, 1'b1, 3'h0);
    wr(CTRL_OFS, 32'h0);
    @(posedge fsync);
    wait (phase == 8'h05);
    @(posedge aclk);
    chk("tx_oe", 32'h1, 32'(serial_tx_data_oe));
    run <= 1'b0;
    repeat (400) begin
      @(posedge aclk);
      if (power_down) break;
    end
    chk("power_down", 32'h1, 32'(power_down));
    chk("tx_oe", 32'h0, 32'(serial_tx_data_oe));
    report_and_stop();
  end
endmodule : voice_pcm_serial_port_bench
`default_nettype wire
